// File: nbh_host.sv
// NAND flash host: turns register orders from AHB-Lite into asynchronous NAND bus cycles.
// Assumes one NAND target on its pins, and a board that resolves io from io_oe_n_o.
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "nbh_map.svh"
module nbh_host (
	// Clock and reset.
	input  wire logic           clk_i,
	input  wire logic           srst_i,
	// AHB-Lite slave.
	input  wire logic           hsel_i,
	input  wire logic [7:0]     haddr_i,
	input  wire logic [1:0]     htrans_i,
	input  wire logic           hwrite_i,
	input  wire logic [2:0]     hsize_i,
	input  wire logic [31:0]    hwdata_i,
	input  wire logic           hready_i,
	output logic                hreadyout_o,
	output logic                hresp_o,
	output logic [31:0]         hrdata_o,
	// NAND pins.
	output logic                ce_n_o,
	output logic                cle_o,
	output logic                ale_o,
	output logic                we_n_o,
	output logic                re_n_o,
	output logic                wp_n_o,
	output logic [15:0]         io_o,
	output logic                io_oe_n_o,
	input  wire logic [15:0]    io_i,
	input  wire logic           rb_n_i
);
	import nbh_pkg::*;

	localparam logic [2:0] SETUP_CYC = 3'(`NBH_CYC(`NBH_T_SETUP_NS));
	localparam logic [2:0] PULSE_CYC = 3'(`NBH_CYC(`NBH_T_PULSE_NS));
	localparam logic [2:0] HOLD_CYC  = 3'(`NBH_CYC(`NBH_T_HOLD_NS));

	logic [2:0]  ctrl;
	logic [12:0] col;
	logic [18:0] row;
	logic [15:0] cmd_data;
	nbh_op_t     op;
	nbh_state_t  state;
	logic [2:0]  tcnt;
	logic [2:0]  addr_idx;
	logic        refused;
	logic [15:0] rd_data;
	logic        ph_write;
	logic [7:0]  ph_addr;
	logic [15:0] io_s1;
	logic [15:0] io_s2;
	logic        rb_s1;
	logic        rb_s2;
	logic        launch_req;
	logic        launch_ok;
	logic        x16;
	logic [12:0] col_fix;
	logic [7:0]  addr_byte;
	logic [15:0] next_io;
	logic [31:0] rd_mux;

	assign x16 = ctrl[`NBH_CTRL_X16];

	// Pin inputs pass two flip-flops before any logic reads them.
	always_ff @(posedge clk_i) begin
		io_s1 <= io_i;
		io_s2 <= io_s1;
		rb_s1 <= rb_n_i;
		rb_s2 <= rb_s1;
	end

	// AHB address phase is captured; every transfer answers OKAY with no wait state.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ph_write    <= 1'b0;
			ph_addr     <= 8'h00;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
			hrdata_o    <= 32'h0000_0000;
		end else begin
			ph_write <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
			ph_addr  <= haddr_i;
			if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
				hrdata_o <= rd_mux;
			end
		end
	end

	// Read multiplexer; unmapped offsets read zero.
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (haddr_i)
			`NBH_OFF_CTRL: rd_mux = {29'h0, ctrl};
			`NBH_OFF_COL:  rd_mux = {19'h0, col};
			`NBH_OFF_ROW:  rd_mux = {13'h0, row};
			`NBH_OFF_CMD:  rd_mux = {13'h0, op, cmd_data};
			`NBH_OFF_STATUS: begin
				rd_mux = {rd_data, 11'h0, row[18], row[6], refused, rb_s2,
					state != NBH_IDLE};
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// A launch is refused while a cycle runs or, when busy, for non-status commands.
	assign launch_req = ph_write && ph_addr == `NBH_OFF_CMD;
	assign launch_ok  = launch_req && state == NBH_IDLE
		&& (rb_s2 || (hwdata_i[18:16] == 3'(NBH_OP_CMD)
		&& (hwdata_i[7:0] == `NBH_CMD_STATUS
		|| hwdata_i[7:0] == `NBH_CMD_STATUS_E)));

	// Software-written configuration and address registers.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ctrl <= `NBH_CTRL_RST;
			col  <= 13'h0000;
			row  <= 19'h00000;
		end else if (ph_write && state == NBH_IDLE) begin
			if (ph_addr == `NBH_OFF_CTRL) begin
				ctrl <= hwdata_i[2:0];
			end
			if (ph_addr == `NBH_OFF_COL) begin
				col <= hwdata_i[12:0];
			end
			if (ph_addr == `NBH_OFF_ROW) begin
				row <= hwdata_i[18:0];
			end
		end
	end

	// Refused flag stays until the next accepted launch.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			refused <= 1'b0;
		end else if (launch_ok) begin
			refused <= 1'b0;
		end else if (launch_req) begin
			refused <= 1'b1;
		end
	end

	// Column with forbidden bits cleared, then the byte for the current address cycle.
	always_comb begin
		col_fix = col;
		if (x16) begin
			col_fix[12] = 1'b0;
			if (col[11]) begin
				col_fix[10:7] = 4'h0;
			end
		end else if (col[12]) begin
			col_fix[11:8] = 4'h0;
		end
		unique case (addr_idx)
			3'h0: addr_byte = col_fix[7:0];
			3'h1: addr_byte = {3'h0, col_fix[12:8]};
			3'h2: addr_byte = row[7:0];
			3'h3: addr_byte = row[15:8];
			3'h4: addr_byte = {5'h00, row[18:16]};
			default: addr_byte = 8'h00;
		endcase
	end

	// Value placed on io for the current cycle.
	always_comb begin
		next_io = 16'h0000;
		unique case (op)
			NBH_OP_CMD:   next_io = {8'h00, cmd_data[7:0]};
			NBH_OP_ADDR:  next_io = {8'h00, addr_byte};
			NBH_OP_WDATA: next_io = x16 ? cmd_data : {8'h00, cmd_data[7:0]};
			default:      next_io = 16'h0000;
		endcase
	end

	// Cycle sequencer: setup with strobes high, strobe pulse, hold with strobes high.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state    <= NBH_IDLE;
			tcnt     <= 3'h0;
			addr_idx <= 3'h0;
			op       <= NBH_OP_CMD;
			cmd_data <= 16'h0000;
		end else begin
			unique case (state)
				NBH_IDLE: begin
					if (launch_ok) begin
						op       <= nbh_op_t'(hwdata_i[18:16]);
						cmd_data <= hwdata_i[15:0];
						addr_idx <= 3'h0;
						tcnt     <= SETUP_CYC;
						state    <= NBH_SETUP;
					end
				end
				NBH_SETUP: begin
					tcnt <= tcnt - 3'h1;
					if (tcnt == 3'h1) begin
						tcnt  <= PULSE_CYC;
						state <= NBH_PULSE;
					end
				end
				NBH_PULSE: begin
					tcnt <= tcnt - 3'h1;
					if (tcnt == 3'h1) begin
						tcnt  <= HOLD_CYC;
						state <= NBH_HOLD;
					end
				end
				NBH_HOLD: begin
					tcnt <= tcnt - 3'h1;
					if (tcnt == 3'h1) begin
						if (op == NBH_OP_ADDR && addr_idx != `NBH_ADDR_CYCLES - 3'h1) begin
							addr_idx <= addr_idx + 3'h1;
							tcnt     <= SETUP_CYC;
							state    <= NBH_SETUP;
						end else begin
							state <= NBH_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Read data is taken on the first hold edge, once the word driven at the strobe fall
	// has crossed the two-flop synchroniser; word-wide in x16 mode.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rd_data <= 16'h0000;
		end else if (state == NBH_HOLD && tcnt == HOLD_CYC && op == NBH_OP_RDATA) begin
			rd_data <= x16 ? io_s2 : {8'h00, io_s2[7:0]};
		end
	end

	// Pin drivers; latch enables and io stay steady through setup, pulse and hold.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ce_n_o    <= 1'b1;
			cle_o     <= 1'b0;
			ale_o     <= 1'b0;
			we_n_o    <= 1'b1;
			re_n_o    <= 1'b1;
			wp_n_o    <= 1'b0;
			io_o      <= 16'h0000;
			io_oe_n_o <= 1'b1;
		end else begin
			wp_n_o <= ctrl[`NBH_CTRL_WP_EN];
			ce_n_o <= !(ctrl[`NBH_CTRL_CE_HOLD] || state != NBH_IDLE);
			if (state == NBH_IDLE) begin
				cle_o     <= 1'b0;
				ale_o     <= 1'b0;
				io_oe_n_o <= 1'b1;
			end else begin
				cle_o     <= op == NBH_OP_CMD;
				ale_o     <= op == NBH_OP_ADDR;
				io_o      <= next_io;
				io_oe_n_o <= op == NBH_OP_RDATA;
			end
			we_n_o <= !(state == NBH_PULSE && op != NBH_OP_RDATA);
			re_n_o <= !(state == NBH_PULSE && op == NBH_OP_RDATA);
		end
	end
endmodule // nbh_host
`default_nettype wire

// File: nbh_host_checker.sv
// Pin timing checks for the NAND bus host.
// Assumes it is bound to nbh_host and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module nbh_host_checker (
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        srst_i,
	// NAND pins.
	input wire logic        ce_n_o,
	input wire logic        cle_o,
	input wire logic        ale_o,
	input wire logic        we_n_o,
	input wire logic        re_n_o,
	input wire logic [15:0] io_o,
	input wire logic        io_oe_n_o
);
	// All checks share one clock and reset.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);
	latch_excl_a: assert property (!(cle_o && ale_o))
		else $error("both latch enables high");
	strobe_excl_a: assert property (we_n_o || re_n_o)
		else $error("both strobes low");
	strobe_ce_a: assert property (!(we_n_o && re_n_o) |-> !ce_n_o)
		else $error("strobe without chip enable");
	we_pulse_a: assert property ($fell(we_n_o) |-> !we_n_o[*3] ##1 we_n_o)
		else $error("write strobe width");
	re_pulse_a: assert property ($fell(re_n_o) |-> !re_n_o[*3] ##1 re_n_o)
		else $error("read strobe width");
	we_setup_a: assert property ($fell(we_n_o) |-> $stable(cle_o) && $stable(ale_o))
		else $error("latch enable moved at strobe");
	we_hold_a: assert property ($rose(we_n_o) |-> $stable(io_o) && $stable(cle_o) && $stable(ale_o))
		else $error("hold broken");
	upper_zero_a: assert property ((cle_o || ale_o) |-> io_o[15:8] == 8'h00)
		else $error("upper byte set");
	bus_dir_a: assert property (!re_n_o |-> io_oe_n_o)
		else $error("host drives during read");
endmodule // nbh_host_checker
bind nbh_host nbh_host_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .ce_n_o(ce_n_o),
	.cle_o(cle_o), .ale_o(ale_o), .we_n_o(we_n_o), .re_n_o(re_n_o), .io_o(io_o),
	.io_oe_n_o(io_oe_n_o));
`default_nettype wire

// File: nbh_map.svh
// Register offsets, field positions, reset values and timing counts for the NAND bus host.
// Assumes a 50 MHz clock and a 32-bit AHB-Lite register window.
`ifndef NBH_MAP_SVH
`define NBH_MAP_SVH
`define NBH_OFF_CTRL     8'h00
`define NBH_OFF_COL      8'h04
`define NBH_OFF_ROW      8'h08
`define NBH_OFF_CMD      8'h0C
`define NBH_OFF_STATUS   8'h10
`define NBH_CTRL_WP_EN   0
`define NBH_CTRL_X16     1
`define NBH_CTRL_CE_HOLD 2
`define NBH_CTRL_RST     3'h0
`define NBH_CMD_OP_LSB   16
`define NBH_ST_BUSY      0
`define NBH_ST_READY     1
`define NBH_ST_REFUSED   2
`define NBH_ST_PLANE     3
`define NBH_ST_DIE       4
`define NBH_ST_DATA_LSB  16
`define NBH_CMD_STATUS   8'h70
`define NBH_CMD_STATUS_E 8'h78
`define NBH_ADDR_CYCLES  3'h5
`define NBH_CLK_NS       20
`define NBH_T_SETUP_NS   20
`define NBH_T_PULSE_NS   60
`define NBH_T_HOLD_NS    20
`define NBH_CYC(t)       (((t) + `NBH_CLK_NS - 1) / `NBH_CLK_NS)
`endif

// File: nbh_nand_model.sv
// Behavioural NAND die on the far side of the bus host.
// Assumes busy_i stands for an internal array operation.
`timescale 1ns/1ns
`default_nettype none
module nbh_nand_model (
	// Host pins.
	input wire logic        ce_n_i,
	input wire logic        cle_i,
	input wire logic        ale_i,
	input wire logic        we_n_i,
	input wire logic        re_n_i,
	input wire logic [15:0] io_i,
	// Die state.
	input wire logic        busy_i,
	output logic [15:0]     io_o,
	output logic            rb_n_o
);
	logic [7:0]  cmd = 8'h00;
	logic [7:0]  adr[$];
	logic [15:0] dat[$];
	logic [15:0] word = 16'h1234;
	// Ready pin follows the internal operation.
	assign rb_n_o = !busy_i;
	// Cycles decode at the write strobe rise; a deselected die ignores all.
	always @(posedge we_n_i) begin
		if (!ce_n_i && re_n_i) begin
			if (cle_i && !ale_i && (!busy_i || io_i[7:0] inside {8'h70, 8'h78}))
				cmd = io_i[7:0];
			else if (ale_i && !cle_i)
				adr.push_back(io_i[7:0]);
			else if (!cle_i && !ale_i && !busy_i)
				dat.push_back(io_i);
		end
	end
	// Next word at the read strobe fall; a released bus shows the inverse.
	always @(negedge re_n_i) begin
		if (!ce_n_i && !cle_i && !ale_i && we_n_i && !busy_i) begin
			io_o = word;
			word = word + 16'h0101;
		end
	end
	always @(posedge re_n_i) io_o = ~io_o;
	initial io_o = 16'h0000;
endmodule // nbh_nand_model
`default_nettype wire

// File: nbh_pkg.sv
// Types shared by the NAND bus host.
// Assumes nothing of its surroundings.
`default_nettype none
package nbh_pkg;
	typedef enum logic [1:0] {NBH_IDLE, NBH_SETUP, NBH_PULSE, NBH_HOLD} nbh_state_t;
	typedef enum logic [2:0] {
		NBH_OP_CMD   = 3'h0,
		NBH_OP_ADDR  = 3'h1,
		NBH_OP_WDATA = 3'h2,
		NBH_OP_RDATA = 3'h3
	} nbh_op_t;
endpackage
`default_nettype wire

// File: tb_nbh_host.sv
// Self-checking bench for the NAND bus host.
// Assumes the behavioural die model and the bound pin checker.
`timescale 1ns/1ns
`default_nettype none
`include "nbh_map.svh"
module tb_nbh_host;
	import nbh_pkg::*;
	typedef struct {nbh_op_t op; logic x16; logic [12:0] col; logic [18:0] row;
		logic [15:0] d; logic [39:0] exp;} nbh_row_t;
	logic clk_i, srst_i, hsel_i, hwrite_i, hrdy, busy, ce_n, cle, ale, we_n, re_n, wp_n, oe_n, rb_n;
	logic hresp;
	logic [7:0]  haddr_i;
	logic [1:0]  htrans_i;
	logic [31:0] hwdata_i, hrdata, rd;
	logic [15:0] io_h, io_d, io_w;
	logic [39:0] got;
	int          num_errors = 0;
	int          samples_checked = 0;
	nbh_row_t    rows[8] = '{
		'{NBH_OP_CMD, 1'b0, 13'h0, 19'h0, 16'h0080, 40'h80},
		'{NBH_OP_CMD, 1'b1, 13'h0, 19'h0, 16'hAB90, 40'h90},
		'{NBH_OP_ADDR, 1'b0, 13'h0ABC, 19'h5A5C3, 16'h0, 40'h05A5C30ABC},
		'{NBH_OP_ADDR, 1'b0, 13'h1F55, 19'h40040, 16'h0, 40'h0400401055},
		'{NBH_OP_ADDR, 1'b1, 13'h1FFF, 19'h3FFBF, 16'h0, 40'h03FFBF087F},
		'{NBH_OP_WDATA, 1'b1, 13'h0, 19'h0, 16'hA55A, 40'hA55A},
		'{NBH_OP_WDATA, 1'b0, 13'h0, 19'h0, 16'hA55A, 40'h005A},
		'{NBH_OP_RDATA, 1'b1, 13'h0, 19'h0, 16'h0, 40'h1234}};
	// The bus wire: host drives when its enable is low, else the die.
	assign io_w = oe_n ? io_d : io_h;
	nbh_host uut (.clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
		.hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .ce_n_o(ce_n),
		.cle_o(cle), .ale_o(ale), .we_n_o(we_n), .re_n_o(re_n), .wp_n_o(wp_n), .io_o(io_h),
		.io_oe_n_o(oe_n), .io_i(io_w), .rb_n_i(rb_n));
	nbh_nand_model dev (.ce_n_i(ce_n), .cle_i(cle), .ale_i(ale), .we_n_i(we_n), .re_n_i(re_n),
		.io_i(io_w), .busy_i(busy), .io_o(io_d), .rb_n_o(rb_n));
	// Free-running 50 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One bus phase: wait a bounded time for ready.
	task automatic phase();
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hrdy !== 1'b1 && n < 100);
		if (hrdy !== 1'b1) begin
			chk(40'h0, 40'h1);
			summarize();
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		phase();
		htrans_i <= 2'h0;
		hwdata_i <= d;
		phase();
		rd = hrdata;
	endtask
	// Launch one pin operation and poll status until it is idle.
	task automatic op(input nbh_op_t o, input logic [15:0] d);
		bus(1'b1, `NBH_OFF_CMD, {13'h0, o, d});
		for (int n = 0; n < 40; n++) begin
			bus(1'b0, `NBH_OFF_STATUS, 32'h0);
			if (rd[`NBH_ST_BUSY] === 1'b0)
				return;
		end
		chk(40'h0, 40'h1);
		summarize();
	endtask
	initial begin
		{hsel_i, hwrite_i, busy, haddr_i, htrans_i, hwdata_i} = '0;
		srst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		foreach (rows[i]) begin
			bus(1'b1, `NBH_OFF_CTRL, {30'h0, rows[i].x16, 1'b1});
			bus(1'b1, `NBH_OFF_COL, {19'h0, rows[i].col});
			bus(1'b1, `NBH_OFF_ROW, {13'h0, rows[i].row});
			op(rows[i].op, rows[i].d);
			case (rows[i].op)
				NBH_OP_CMD: got = {32'h0, dev.cmd};
				NBH_OP_ADDR: got = {dev.adr[4], dev.adr[3], dev.adr[2], dev.adr[1], dev.adr[0]};
				NBH_OP_WDATA: got = {24'h0, dev.dat.pop_front()};
				default: got = {24'h0, rd[31:16]};
			endcase
			chk(got, rows[i].exp);
			chk({ce_n, wp_n, hresp, rd[`NBH_ST_DIE], rd[`NBH_ST_PLANE]},
				{3'h6, rows[i].row[18], rows[i].row[6]});
			dev.adr.delete();
		end
		// An x8 read keeps only the low byte of the second model word.
		bus(1'b1, `NBH_OFF_CTRL, 32'h0000_0001);
		op(NBH_OP_RDATA, 16'h0000);
		chk({24'h0, rd[31:16]}, 40'h35);
		// A busy die refuses ordinary commands but takes the status reads.
		busy <= 1'b1;
		repeat (3) @(posedge clk_i);
		op(NBH_OP_CMD, 16'h0080);
		chk({dev.cmd, rd[`NBH_ST_REFUSED], rd[`NBH_ST_READY]}, {8'h90, 2'h2});
		op(NBH_OP_CMD, 16'h0070);
		chk({dev.cmd, rd[`NBH_ST_REFUSED]}, {8'h70, 1'b0});
		op(NBH_OP_CMD, 16'h0078);
		chk({dev.cmd, rd[`NBH_ST_REFUSED]}, {8'h78, 1'b0});
		busy <= 1'b0;
		// Chip enable held by software while idle, with write protect asserted.
		bus(1'b1, `NBH_OFF_CTRL, 32'h0000_0004);
		repeat (2) @(posedge clk_i);
		chk({38'h0, ce_n, wp_n}, 40'h0);
		// Second reset in mid-run returns the pins to standby and protect.
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk({ce_n, cle, ale, we_n, re_n, wp_n, oe_n, io_h}, {7'h4D, 16'h0});
		bus(1'b0, `NBH_OFF_CTRL, 32'h0);
		chk({8'h0, rd}, 40'h0);
		bus(1'b0, 8'h40, 32'h0);
		chk({8'h0, rd}, 40'h0);
		summarize();
	end
endmodule // tb_nbh_host
`default_nettype wire
